// *** core/scs_clock_stop_ctrl.sv ***
// Suspend clock-stop controller: suspend handshake, clock-stop pin, resync delay
// Functional notes
// - After break ends full suspend, wait delay-field milliseconds before releasing request.
// - Delay applies only if clock-stop select was set at suspend entry.
// - Delay field is plain binary milliseconds, 0 to 15.
// - Select bit chooses handshake-only suspend or full system suspend.
// - Select clear: handshake only, clock-stop indicator stays inactive.
// - Handshake-only suspend: release request as soon as break occurs.
// - Select set: after handshake, assert clock-stop indicator.
// - Full suspend break: drop indicator, run delay, then release request.
// - Indicator asserts only after processor acknowledges request.
// - Management event or unmasked interrupt while stopped is a break.
// - Management interrupt output held asserted throughout resync delay.
// - Indicator pin sampled at reset as inactive level; opposite drives active.
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/100ps
module scs_clock_stop_ctrl
    import scs_pkg::*;
#(
    parameter int MS_CYCLES = SCS_MS_CYCLES
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic cpu_suspend_request_n,
    input wire logic cpu_suspend_ack_n,
    input wire logic mgmt_event,
    input wire logic [7:0] irq_in,
    input wire logic [7:0] irq_mask,
    output logic mgmt_interrupt_n,
    input wire logic clock_stop_indicator_in,
    output logic clock_stop_indicator_out,
    output logic clock_stop_indicator_oe_n
);
    scs_bus_t bus;
    scs_state_t state;
    scs_state_t next_state;
    logic [7:0] ctrl;
    logic full_mode;
    logic inactive_level;
    logic strap_taken;
    logic stop_active;
    logic [SCS_SYNC_STAGES-1:0] ack_sync;
    logic [SCS_SYNC_STAGES-1:0] smi_sync;
    logic [SCS_SYNC_STAGES-1:0] ind_sync;
    logic [7:0] irq_s1;
    logic [7:0] irq_s2;
    logic [7:0] irq_s3;
    logic [7:0] irq_q;
    logic ack_q;
    logic smi_q;
    logic hold_smi;
    logic [1:0] strap_fill;
    logic [31:0] resync_cycles;

    assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // Three-stage input synchronisers; a level counts when stages two and three agree
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ack_sync <= 3'b111;
            smi_sync <= 3'b000;
            ind_sync <= 3'b000;
            irq_s1 <= 8'h00;
            irq_s2 <= 8'h00;
            irq_s3 <= 8'h00;
        end else begin
            ack_sync <= {ack_sync[1:0], cpu_suspend_ack_n};
            smi_sync <= {smi_sync[1:0], mgmt_event};
            ind_sync <= {ind_sync[1:0], clock_stop_indicator_in};
            irq_s1 <= irq_in;
            irq_s2 <= irq_s1;
            irq_s3 <= irq_s2;
        end
    end

    // Filtered levels hold until the last two stages agree
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ack_q <= 1'b0;
            smi_q <= 1'b0;
            irq_q <= 8'h00;
        end else begin
            if (ack_sync[1] == ack_sync[2]) begin
                ack_q <= !ack_sync[2];
            end
            if (smi_sync[1] == smi_sync[2]) begin
                smi_q <= smi_sync[2];
            end
            // Per line: set when both stages high, clear when both low, else hold
            irq_q <= (irq_s2 & irq_s3) | (irq_q & (irq_s2 | irq_s3));
        end
    end

    // Interrupt lines count only once filtered and with the mask clear
    wire [7:0] irq_agree = irq_q & ~irq_mask;
    wire break_event = smi_q || (irq_agree != 8'h00);

    // Strap catch after release: the pin is still an input here
    // Waits until the synchroniser holds only pin samples, else the reset fill reads as strap
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            inactive_level <= 1'b0;
            strap_taken <= 1'b0;
            strap_fill <= 2'h0;
        end else if (strap_fill != 2'(SCS_SYNC_STAGES)) begin
            strap_fill <= strap_fill + 2'h1;
        end else if (!strap_taken && (ind_sync[1] == ind_sync[2])) begin
            inactive_level <= ind_sync[2];
            strap_taken <= 1'b1;
        end
    end

    // Register decode
    wire wr_ctrl = bus.wr && (bus.addr == SCS_ADDR_CTRL);
    wire wr_cmd = bus.wr && (bus.addr == SCS_ADDR_CMD) && strap_taken;
    wire [7:0] status_word = {4'h0, stop_active, 3'(state)};
    wire [7:0] next_rdata = (bus.addr == SCS_ADDR_CTRL) ? ctrl :
                            (bus.addr == SCS_ADDR_STATUS) ? status_word : 8'h00;

    // Control register; reserved bits held at zero whatever is written
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ctrl <= SCS_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl <= bus.wdata & SCS_CTRL_WMASK;
        end
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= bus.rd ? next_rdata : 8'h00;
        end
    end

    // Resync delay timer
    logic delay_start;
    logic delay_done;
    scs_ms_timer #(.MS_CYCLES(MS_CYCLES)) scs_ms_timer_inst (
        .clock(clock),
        .resetn(resetn),
        .start(delay_start),
        .ms_count(ctrl[SCS_DLY_MSB:SCS_DLY_LSB]),
        .done(delay_done)
    );

    // Sequencer transitions
    always_comb begin
        next_state = state;
        delay_start = 1'b0;
        unique case (state)
            SCS_IDLE: begin
                if (wr_cmd) begin
                    next_state = SCS_REQ;
                end
            end
            SCS_REQ: begin
                if (ack_q) begin
                    next_state = full_mode ? SCS_STOP : SCS_HALT;
                end
            end
            SCS_HALT: begin
                if (break_event) begin
                    next_state = SCS_IDLE;
                end
            end
            SCS_STOP: begin
                if (break_event) begin
                    next_state = SCS_RESYNC;
                    delay_start = 1'b1;
                end
            end
            SCS_RESYNC: begin
                if (delay_done) begin
                    next_state = SCS_IDLE;
                end
            end
            default: begin
                next_state = SCS_IDLE;
            end
        endcase
    end

    // State, mode latched at entry, management hold
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= SCS_IDLE;
            full_mode <= 1'b0;
            hold_smi <= 1'b0;
        end else begin
            state <= next_state;
            if (state == SCS_IDLE && wr_cmd) begin
                full_mode <= ctrl[SCS_SEL_BIT];
            end
            hold_smi <= (next_state == SCS_RESYNC);
        end
    end

    // Outputs; the indicator only leaves idle level in the stop state
    assign stop_active = (state == SCS_STOP);
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cpu_suspend_request_n <= 1'b1;
            mgmt_interrupt_n <= 1'b1;
            clock_stop_indicator_out <= 1'b0;
            clock_stop_indicator_oe_n <= 1'b1;
        end else begin
            cpu_suspend_request_n <= (next_state == SCS_IDLE);
            mgmt_interrupt_n <= !hold_smi && !(next_state == SCS_RESYNC);
            clock_stop_indicator_out <= (next_state == SCS_STOP) ? !inactive_level : inactive_level;
            clock_stop_indicator_oe_n <= !strap_taken;
        end
    end

    // Cycles spent in resync; a millisecond is far beyond any sequence delay, so count here
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            resync_cycles <= 32'h0;
        end else begin
            resync_cycles <= (state == SCS_RESYNC) ? resync_cycles + 32'h1 : 32'h0;
        end
    end

    a_ind_after_ack: assert property (@(posedge clock) disable iff (!resetn)
        $rose(state == SCS_STOP) |-> ack_q && !cpu_suspend_request_n)
        else $error("indicator entered without acknowledge");
    a_halt_no_stop: assert property (@(posedge clock) disable iff (!resetn)
        (state == SCS_HALT) |-> (clock_stop_indicator_out == inactive_level))
        else $error("indicator active in handshake-only suspend");
    a_halt_release: assert property (@(posedge clock) disable iff (!resetn)
        (state == SCS_HALT && break_event) |=> cpu_suspend_request_n)
        else $error("request not released after break");
    a_stop_level: assert property (@(posedge clock) disable iff (!resetn)
        (state == SCS_STOP) |-> clock_stop_indicator_out != inactive_level)
        else $error("indicator not driven active");
    a_resync_hold: assert property (@(posedge clock) disable iff (!resetn)
        (state == SCS_RESYNC) |-> (!cpu_suspend_request_n && !mgmt_interrupt_n
        && clock_stop_indicator_out == inactive_level))
        else $error("resync outputs wrong");
    a_zero_delay: assert property (@(posedge clock) disable iff (!resetn)
        (delay_start && ctrl[SCS_DLY_MSB:SCS_DLY_LSB] == 4'h0) |=> (state == SCS_RESYNC) ##1 (state == SCS_IDLE))
        else $error("zero delay not immediate");
    a_mode_latch: assert property (@(posedge clock) disable iff (!resetn)
        (state == SCS_REQ && ack_q && !full_mode) |=> (state == SCS_HALT))
        else $error("handshake-only went to stop");
    a_reserved_zero: assert property (@(posedge clock) disable iff (!resetn)
        ctrl[3:1] == 3'b000)
        else $error("reserved bits set");
    a_break_stop: assert property (@(posedge clock) disable iff (!resetn)
        (state == SCS_STOP && break_event) |=> (state == SCS_RESYNC))
        else $error("break ignored while stopped");
    a_delay_bound: assert property (@(posedge clock) disable iff (!resetn)
        (state == SCS_RESYNC && delay_done)
        |-> (resync_cycles == 32'(ctrl[SCS_DLY_MSB:SCS_DLY_LSB] * MS_CYCLES)))
        else $error("resync delay length wrong");
endmodule : scs_clock_stop_ctrl

// *** core/scs_ms_timer.sv ***
// Millisecond down-counter for the resynchronisation delay
`timescale 1ns/100ps
module scs_ms_timer
    import scs_pkg::*;
#(
    parameter int MS_CYCLES = SCS_MS_CYCLES
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic start,
    input wire logic [3:0] ms_count,
    output logic done
);
    logic [31:0] tick_cnt;
    logic [3:0] ms_left;
    logic running;
    wire tick = running && (tick_cnt == 32'(MS_CYCLES - 1));

    // Prescaler gives a one-cycle millisecond enable
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tick_cnt <= 32'h0;
        end else if (start || tick) begin
            tick_cnt <= 32'h0;
        end else if (running) begin
            tick_cnt <= tick_cnt + 32'h1;
        end
    end

    // Plain binary count of milliseconds, zero finishes at once
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ms_left <= 4'h0;
            running <= 1'b0;
            done <= 1'b0;
        end else if (start) begin
            ms_left <= ms_count;
            running <= (ms_count != 4'h0);
            done <= (ms_count == 4'h0);
        end else if (tick) begin
            ms_left <= ms_left - 4'h1;
            running <= (ms_left != 4'h1);
            done <= (ms_left == 4'h1);
        end else begin
            done <= 1'b0;
        end
    end
endmodule : scs_ms_timer

// *** core/scs_pkg.sv ***
// Package for the suspend clock-stop controller: register map, fields, timing
package scs_pkg;
    // Register indices on the plain register port
    localparam logic [3:0] SCS_ADDR_CTRL = 4'h0;
    localparam logic [3:0] SCS_ADDR_CMD = 4'h1;
    localparam logic [3:0] SCS_ADDR_STATUS = 4'h2;
    // Field positions of clock_stop_control
    localparam int SCS_SEL_BIT = 0;
    localparam int SCS_DLY_LSB = 4;
    localparam int SCS_DLY_MSB = 7;
    localparam logic [7:0] SCS_CTRL_RESET = 8'h00;
    localparam logic [7:0] SCS_CTRL_WMASK = 8'hF1;
    // Timing: one millisecond at the system clock rate
    localparam int SCS_CLK_MHZ = 100;
    localparam int SCS_MS_US = 1000;
    localparam int SCS_MS_CYCLES = SCS_CLK_MHZ * SCS_MS_US;
    localparam int SCS_SYNC_STAGES = 3;

    typedef enum logic [2:0] {
        SCS_IDLE = 3'b000,
        SCS_REQ = 3'b001,
        SCS_HALT = 3'b010,
        SCS_STOP = 3'b011,
        SCS_RESYNC = 3'b100
    } scs_state_t;

    // Register port request bundle
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } scs_bus_t;
endpackage : scs_pkg

// *** test/scs_clock_stop_ctrl_tb.sv ***
// Self-checking testbench for the suspend clock-stop controller
`timescale 1ns/100ps
module scs_clock_stop_ctrl_tb
    import scs_pkg::*;
;
    localparam int MSC = 10;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    scs_bus_t bus = '0;
    logic ack_n, req_n, smi_n, ind_out, ind_oe_n;
    logic strap = 1'b0;
    logic mgmt = 1'b0;
    logic [7:0] rdata;
    logic [7:0] irq = 8'h00;
    logic [7:0] mask = 8'h00;
    logic [4:0] ack_dly = 5'h08;
    logic rd_d = 1'b0;
    logic req_d = 1'b1;
    integer seed = 32'hef27;
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int brk_cnt = 0;
    logic [7:0] rd_q[$];
    int lo_q[$];
    // Pull resistor sets the pin level while the controller leaves it undriven
    wire ind_pin = ind_oe_n ? strap : ind_out;

    scs_clock_stop_ctrl #(.MS_CYCLES(MSC)) scs_clock_stop_ctrl_inst (.clock(clock), .resetn(resetn),
        .reg_addr(bus.addr), .reg_wdata(bus.wdata), .reg_wr(bus.wr), .reg_rd(bus.rd), .reg_rdata(rdata),
        .cpu_suspend_request_n(req_n), .cpu_suspend_ack_n(ack_n), .mgmt_event(mgmt), .irq_in(irq),
        .irq_mask(mask), .mgmt_interrupt_n(smi_n), .clock_stop_indicator_in(ind_pin),
        .clock_stop_indicator_out(ind_out), .clock_stop_indicator_oe_n(ind_oe_n));
    scs_cpu_model scs_cpu_model_inst (.clock(clock), .resetn(resetn), .cpu_suspend_request_n(req_n),
        .ack_delay(ack_dly), .cpu_suspend_ack_n(ack_n));

    // Free-running 100 MHz clock
    initial begin
        forever #5 clock = ~clock;
    end

    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] seen);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : cmp

    // Latency window covers the synchroniser and one registered stage
    task automatic cmp_rng(input string what, input int lo, input int seen);
        n_checks++;
        if (seen < lo || seen > lo + 8) begin
            n_errors++;
            $display("[ERR] %s expected %0d to %0d seen %0d", what, lo, lo + 8, seen);
        end
    endtask : cmp_rng

    task automatic complete_run();
        if (n_errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        rd_q.push_back(exp);
        @(posedge clock);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus.rd <= 1'b0;
    endtask : rd

    task automatic do_reset(input logic lvl);
        @(posedge clock);
        resetn <= 1'b0;
        strap <= lvl;
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        repeat (8) @(posedge clock);
    endtask : do_reset

    // One suspend cycle; masked interrupts first, which must not wake anything
    task automatic suspend(input logic sel, input logic [3:0] n, input logic use_irq);
        int t;
        wr(SCS_ADDR_CTRL, {n, 3'b000, sel});
        ack_dly <= 5'(8 + ($random(seed) & 15));
        wr(SCS_ADDR_CMD, 8'h00);
        repeat (4) @(posedge clock);
        cmp("indicator before ack", strap, ind_pin);
        t = 0;
        while (ack_n !== 1'b0 && t < 100) begin
            @(posedge clock);
            t++;
        end
        cmp("acknowledge within limit", 8'h00, ack_n);
        repeat (8) @(posedge clock);
        cmp("indicator in suspend", sel ? !strap : strap, ind_pin);
        rd(SCS_ADDR_STATUS, {4'h0, sel, sel ? SCS_STOP : SCS_HALT});
        irq <= mask;
        repeat (10) @(posedge clock);
        cmp("request under masked irq", 8'h00, req_n);
        lo_q.push_back(sel ? n * MSC : 0);
        if (use_irq) begin
            irq <= mask | 8'h80;
        end else begin
            mgmt <= 1'b1;
        end
        repeat (6) @(posedge clock);
        cmp("indicator after break", strap, ind_pin);
        if (sel && n != 4'h0) begin
            cmp("mgmt interrupt in delay", 8'h00, smi_n);
        end
        if (!sel) begin
            cmp("mgmt interrupt handshake only", 8'h01, smi_n);
        end
        t = 0;
        while (req_n !== 1'b1 && t < 400) begin
            @(posedge clock);
            t++;
        end
        cmp("release within limit", 8'h01, req_n);
        @(posedge clock);
        irq <= 8'h00;
        mgmt <= 1'b0;
        cmp("mgmt interrupt after release", 8'h01, smi_n);
    endtask : suspend

    // Monitor: read data and release latency against the oldest noted value
    always @(posedge clock) begin
        rd_d <= bus.rd;
        req_d <= req_n;
        brk_cnt <= (mgmt || (irq & ~mask) != 8'h00) ? brk_cnt + 1 : 0;
        cyc <= cyc + 1;
        if (rd_d) begin
            cmp("read data", rd_q.pop_front(), rdata);
        end
        if (req_n && !req_d && lo_q.size() > 0) begin
            cmp_rng("release delay", lo_q.pop_front(), brk_cnt);
        end
        if (cyc > 5000) begin
            n_errors++;
            complete_run();
        end
    end

    // Main sequence, once per strap level
    initial begin
        for (int s = 0; s < 2; s++) begin
            do_reset(s[0]);
            mask <= (8'($random(seed)) & 8'h7E) | 8'h01;
            rd(SCS_ADDR_CTRL, SCS_CTRL_RESET);
            cmp("pin enable after strap", 8'h00, ind_oe_n);
            wr(SCS_ADDR_CTRL, 8'hF1);
            rd(SCS_ADDR_CTRL, 8'hF1);
            rd(4'hF, 8'h00);
            suspend(1'b0, 4'hF, s[0]);
            suspend(1'b1, 4'h0, 1'b1);
            suspend(1'b1, 4'hF, 1'b0);
            suspend(1'b1, 4'($random(seed)), ~s[0]);
        end
        repeat (4) @(posedge clock);
        complete_run();
    end
endmodule : scs_clock_stop_ctrl_tb

// *** test/scs_cpu_model.sv ***
// Processor model: answers the suspend request after a chosen number of cycles
`timescale 1ns/100ps
module scs_cpu_model (
    input wire logic clock,
    input wire logic resetn,
    input wire logic cpu_suspend_request_n,
    input wire logic [4:0] ack_delay,
    output logic cpu_suspend_ack_n
);
    logic [4:0] wait_cnt;
    // Halt after ack_delay cycles, hold the acknowledge until the request drops
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wait_cnt <= 5'h00;
            cpu_suspend_ack_n <= 1'b1;
        end else if (cpu_suspend_request_n) begin
            wait_cnt <= 5'h00;
            cpu_suspend_ack_n <= 1'b1;
        end else if (wait_cnt >= ack_delay) begin
            cpu_suspend_ack_n <= 1'b0;
        end else begin
            wait_cnt <= wait_cnt + 5'h01;
        end
    end
endmodule : scs_cpu_model
